// File: pkg/twe_pkg.sv
// Shared constants and carrier types for the two-wire EEPROM target
package twe_pkg;
  // Clock and programming time
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 3000000;
  // Longest time, so round down
  localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
  // Device type code; value is arbitrary
  localparam logic [3:0] TWE_TYPE_CODE = 4'h5;
  // Density selections
  localparam int DENS_2K = 0;
  localparam int DENS_4K = 1;
  localparam int DENS_8K = 2;
  localparam int DENS_16K = 3;
  // Address and page geometry
  localparam int BASE_AW = 8;
  localparam int MAX_AW = 11;
  localparam int PAGE_MAX = 16;
  localparam logic [MAX_AW-1:0] PAGE_MASK_SMALL = 11'h007;
  localparam logic [MAX_AW-1:0] PAGE_MASK_LARGE = 11'h00f;
  // Bit counting within a word
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [3:0] LAST_OUT_BIT = 4'h7;
  // Select-pin compare masks per density
  localparam logic [2:0] SEL_MASK_2K = 3'h7;
  localparam logic [2:0] SEL_MASK_4K = 3'h6;
  localparam logic [2:0] SEL_MASK_8K = 3'h4;
  localparam logic [2:0] SEL_MASK_16K = 3'h0;

  // Serial bus pins as sampled
  typedef struct packed {
    logic scl;
    logic sda;
  } twe_bus_in_t;

  // Array write request
  typedef struct packed {
    logic en;
    logic [MAX_AW-1:0] addr;
    logic [7:0] data;
  } twe_wr_t;
endpackage

// File: core/twe_array.sv
// Flip-flop storage for the EEPROM array
`timescale 1ns/1ps
module twe_array import twe_pkg::*; #(
  parameter int AW = MAX_AW
) (
  // Clock
  input wire logic clk_in,
  input wire logic ce_in,
  // Write port
  input wire twe_wr_t wr_in,
  // Read port
  input wire logic [MAX_AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  localparam int DEPTH = 1 << AW;

  // Whole module state: the array itself
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } twe_array_state_t;

  twe_array_state_t state_reg; // Stored bytes, kept through reset
  twe_array_state_t state_next; // Next array contents

  // Apply one byte write per cycle
  always_comb begin
    state_next = state_reg;
    if (ce_in && wr_in.en) begin
      state_next.mem[wr_in.addr[AW-1:0]] = wr_in.data;
    end
  end

  // Nonvolatile contents: no reset value
  always_ff @(posedge clk_in) begin
    state_reg <= state_next;
  end

  // Read from the addressed flip-flops
  assign rd_data_out = state_reg.mem[rd_addr_in[AW-1:0]];
endmodule

// File: core/twe_target.sv
// Two-wire serial EEPROM target: protocol engine, page staging and programming
// Contract
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Data changes only while SCL low
// - Sample on SCL rise, drive after fall
// - Acknowledge each received byte on ninth clock
// - Standby at reset and after stop
// - Upper four address bits match type code
// - 2K compares all three select pins
// - 4K compares two pins, one page bit
// - 8K compares one pin, two page bits
// - 16K compares none; page bits high address
// - Address word low bit selects read/write
// - Mismatch gives no acknowledge, goes standby
// - Address width eight to eleven bits
// - Byte write launches programming on stop
// - Programming ignores bus, lasts 3 ms
// - Page write accepts up to page length
// - Only in-page address bits increment
// - Excess page bytes overwrite earlier ones
// - Polling acknowledged only after programming ends
// - Write protect high protects whole array
// - Counter holds last address plus one
// - Random read via dummy write, repeated start
// - Controller acknowledge continues read; none ends
`timescale 1ns/1ps
module twe_target import twe_pkg::*; #(
  parameter int DENSITY = DENS_16K,
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Serial bus, sampled synchronously
  input wire twe_bus_in_t bus_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps
  input wire logic [2:0] device_select_pins_in,
  input wire logic write_protect_in,
  // Status
  output logic standby_out,
  output logic prog_busy_out
);
  localparam int AW = BASE_AW + DENSITY;

  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_PROG
  } twe_state_t;

  // Whole module state
  typedef struct packed {
    logic scl_q; // Previous SCL sample
    logic sda_q; // Previous SDA sample
    twe_state_t st; // Protocol state
    twe_state_t ack_next; // State after the acknowledge clock
    logic [3:0] cnt; // Bit counter within a word
    logic [7:0] shin; // Incoming shift register
    logic [7:0] shout; // Outgoing shift register
    logic drive; // Pull SDA low
    logic host_ack; // Controller acknowledged last read byte
    logic [MAX_AW-1:0] addr; // Internal word address counter
    logic [PAGE_MAX-1:0][7:0] pbuf; // Staged page bytes
    logic [PAGE_MAX-1:0] pvld; // Staged byte valid flags
    logic [31:0] prog_cnt; // Programming cycle timer
  } twe_state_s_t;

  twe_state_s_t state_reg; // Registered state
  twe_state_s_t state_next; // Next state
  twe_wr_t wr; // Array write request
  logic [7:0] rd_data; // Array byte at the counter

  // Select pins compared for this density
  function automatic logic [2:0] sel_mask(input int dens);
    unique case (dens)
      DENS_2K: sel_mask = SEL_MASK_2K;
      DENS_4K: sel_mask = SEL_MASK_4K;
      DENS_8K: sel_mask = SEL_MASK_8K;
      default: sel_mask = SEL_MASK_16K;
    endcase
  endfunction

  // In-page offset mask for this density
  function automatic logic [MAX_AW-1:0] page_mask(input int dens);
    page_mask = (dens == DENS_2K) ? PAGE_MASK_SMALL : PAGE_MASK_LARGE;
  endfunction

  // Mask of valid address bits
  function automatic logic [MAX_AW-1:0] addr_mask(input int aw);
    addr_mask = MAX_AW'((1 << aw) - 1);
  endfunction

  // Increment only the in-page bits, wrapping within the page
  function automatic logic [MAX_AW-1:0] page_inc(input logic [MAX_AW-1:0] a);
    logic [MAX_AW-1:0] pm;
    pm = page_mask(DENSITY);
    page_inc = (a & ~pm) | ((a + 11'h001) & pm);
  endfunction

  localparam logic [2:0] SMASK = sel_mask(DENSITY);
  localparam logic [MAX_AW-1:0] PMASK = page_mask(DENSITY);
  localparam logic [MAX_AW-1:0] AMASK = addr_mask(AW);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // Bus events from current and previous samples
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic dev_match;
  logic [3:0] poff;
  logic [4:0] cidx;
  assign scl_rise = bus_in.scl & ~state_reg.scl_q;
  assign scl_fall = ~bus_in.scl & state_reg.scl_q;
  assign start_cond = bus_in.scl & state_reg.scl_q & state_reg.sda_q & ~bus_in.sda;
  assign stop_cond = bus_in.scl & state_reg.scl_q & ~state_reg.sda_q & bus_in.sda;
  // Type code and compared select pins
  assign dev_match = (state_reg.shin[7:4] == TWE_TYPE_CODE)
    && (((state_reg.shin[3:1] ^ device_select_pins_in) & SMASK) == 3'h0);
  assign poff = 4'(state_reg.addr & PMASK);
  assign cidx = 5'(state_reg.prog_cnt);

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    wr = '0;
    if (ce_in) begin
      state_next.scl_q = bus_in.scl;
      state_next.sda_q = bus_in.sda;
      if (state_reg.st == ST_PROG) begin
        // Bus ignored; commit staged bytes then wait out the timer
        state_next.drive = 1'b0;
        if (cidx < 5'(PAGE_MAX) && state_reg.prog_cnt < 32'(PAGE_MAX)) begin
          wr.en = state_reg.pvld[cidx[3:0]];
          wr.addr = (state_reg.addr & ~PMASK) | MAX_AW'(cidx);
          wr.data = state_reg.pbuf[cidx[3:0]];
        end
        state_next.prog_cnt = state_reg.prog_cnt + 32'h1;
        if (state_reg.prog_cnt >= PROG_LAST) begin
          state_next.st = ST_IDLE;
          state_next.pvld = '0;
          state_next.prog_cnt = '0;
        end
      end else if (start_cond) begin
        // Start or repeated start abandons any unfinished write
        state_next.st = ST_DEV;
        state_next.cnt = '0;
        state_next.drive = 1'b0;
        state_next.pvld = '0;
      end else if (stop_cond) begin
        state_next.drive = 1'b0;
        if (state_reg.pvld != '0) begin
          state_next.st = ST_PROG;
          state_next.prog_cnt = '0;
        end else begin
          state_next.st = ST_IDLE;
        end
      end else begin
        unique case (state_reg.st)
          // Standby: wait for a start
          ST_IDLE: begin
            state_next.drive = 1'b0;
          end
          // Receive a word; decide at the fall after bit eight
          ST_DEV, ST_WADDR, ST_WDATA: begin
            if (scl_rise && state_reg.cnt < WORD_BITS) begin
              state_next.shin = {state_reg.shin[6:0], bus_in.sda};
              state_next.cnt = state_reg.cnt + 4'h1;
            end else if (scl_fall && state_reg.cnt == WORD_BITS) begin
              state_next.cnt = '0;
              state_next.st = ST_ACK;
              state_next.drive = 1'b1;
              unique case (state_reg.st)
                ST_DEV: begin
                  if (!dev_match) begin
                    state_next.st = ST_IDLE;
                    state_next.drive = 1'b0;
                  end else if (state_reg.shin[0]) begin
                    state_next.ack_next = ST_RDATA;
                  end else begin
                    state_next.ack_next = ST_WADDR;
                    // Page bits become the top address bits
                    state_next.addr = (state_reg.addr & addr_mask(BASE_AW))
                      | ((MAX_AW'(state_reg.shin[3:1]) << BASE_AW) & AMASK);
                  end
                end
                ST_WADDR: begin
                  state_next.addr = (state_reg.addr & ~addr_mask(BASE_AW))
                    | MAX_AW'(state_reg.shin);
                  state_next.ack_next = ST_WDATA;
                end
                default: begin
                  // Stage data byte unless protected
                  if (!write_protect_in) begin
                    state_next.pbuf[poff] = state_reg.shin;
                    state_next.pvld[poff] = 1'b1;
                  end
                  state_next.addr = page_inc(state_reg.addr);
                  state_next.ack_next = ST_WDATA;
                end
              endcase
            end
          end
          // Hold acknowledge through the ninth clock
          ST_ACK: begin
            if (scl_fall) begin
              state_next.st = state_reg.ack_next;
              state_next.cnt = '0;
              state_next.drive = 1'b0;
              if (state_reg.ack_next == ST_RDATA) begin
                state_next.shout = rd_data;
                state_next.drive = ~rd_data[7];
                state_next.addr = (state_reg.addr + 11'h001) & AMASK;
              end
            end
          end
          // Shift a byte out, one bit per falling edge
          ST_RDATA: begin
            if (scl_fall) begin
              if (state_reg.cnt == LAST_OUT_BIT) begin
                state_next.drive = 1'b0;
                state_next.st = ST_RACK;
              end else begin
                state_next.shout = {state_reg.shout[6:0], 1'b0};
                state_next.drive = ~state_reg.shout[6];
                state_next.cnt = state_reg.cnt + 4'h1;
              end
            end
          end
          // Controller acknowledge decides whether to continue
          ST_RACK: begin
            if (scl_rise) begin
              state_next.host_ack = ~bus_in.sda;
            end else if (scl_fall) begin
              state_next.cnt = '0;
              if (state_reg.host_ack) begin
                state_next.st = ST_RDATA;
                state_next.shout = rd_data;
                state_next.drive = ~rd_data[7];
                state_next.addr = (state_reg.addr + 11'h001) & AMASK;
              end else begin
                state_next.st = ST_IDLE;
              end
            end
          end
          default: begin
            state_next.st = ST_IDLE;
          end
        endcase
      end
    end
  end

  // State register with synchronous reset into standby
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= '0;
      state_reg.scl_q <= 1'b1;
      state_reg.sda_q <= 1'b1;
      state_reg.st <= ST_IDLE;
      state_reg.ack_next <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Storage array
  twe_array #(
    .AW(AW)
  ) u_array (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .wr_in(wr),
    .rd_addr_in(state_reg.addr),
    .rd_data_out(rd_data)
  );

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = state_reg.drive;
  assign standby_out = (state_reg.st == ST_IDLE);
  assign prog_busy_out = (state_reg.st == ST_PROG);
endmodule

// File: testbench/twe_target_monitor.sv
// Port assertions for the two-wire EEPROM target
`timescale 1ns/1ps
module twe_target_monitor import twe_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Bus
  input wire twe_bus_in_t bus_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Straps and status
  input wire logic [2:0] device_select_pins_in,
  input wire logic write_protect_in,
  input wire logic standby_out,
  input wire logic prog_busy_out
);
  logic prev_scl_reg; // Last clock sample
  logic prev_sda_reg; // Last data sample
  int busy_cnt_reg; // Length of current programming run
  logic stop_now; // Stop seen this cycle
  // Bus history and programming length
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_scl_reg <= 1'b1;
      prev_sda_reg <= 1'b1;
      busy_cnt_reg <= 0;
    end else begin
      // History and timer freeze with the block while enable is low
      prev_scl_reg <= ce_in ? bus_in.scl : prev_scl_reg;
      prev_sda_reg <= ce_in ? bus_in.sda : prev_sda_reg;
      busy_cnt_reg <= !prog_busy_out ? 0 : (ce_in ? busy_cnt_reg + 1 : busy_cnt_reg);
    end
  end
  assign stop_now = ce_in & bus_in.scl & prev_scl_reg & bus_in.sda & ~prev_sda_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Clock held high for three samples
  sequence high_phase_s;
    bus_in.scl [*3];
  endsequence
  // Programming or standby shortly after
  sequence settle_s;
    ##[1:2] (standby_out || prog_busy_out);
  endsequence
  open_drain_a: assert property (sda_out == 1'b0) else $error("data output not low");
  drive_low_phase_a: assert property ($rose(sda_oe_out) |->
    !bus_in.scl && ($past(bus_in.scl) || $past(bus_in.scl, 2))) else $error("pull began off clock fall");
  high_phase_hold_a: assert property (high_phase_s |-> $stable(sda_oe_out)) else $error("data moved in high");
  stop_standby_a: assert property (stop_now |-> settle_s) else $error("stop left device active");
  prog_after_stop_a: assert property ($rose(prog_busy_out) |->
    $past(stop_now) || $past(stop_now, 2)) else $error("programming without stop");
  prog_protect_a: assert property ($rose(prog_busy_out) |-> !write_protect_in) else $error("protected write");
  prog_length_a: assert property ($fell(prog_busy_out) |->
    busy_cnt_reg == PROG_CYCLES) else $error("programming length wrong");
  prog_bound_a: assert property (prog_busy_out |-> busy_cnt_reg < PROG_CYCLES) else $error("programming too long");
  busy_quiet_a: assert property (prog_busy_out |-> !sda_oe_out) else $error("ack during programming");
  busy_end_a: assert property ($fell(prog_busy_out) |-> ##[0:1] standby_out) else $error("no standby after");
  freeze_hold_a: assert property (!ce_in |=>
    $stable(prog_busy_out) && $stable(standby_out) && $stable(sda_oe_out)) else $error("state moved while frozen");
endmodule

bind twe_target twe_target_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
  .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .bus_in(bus_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .device_select_pins_in(device_select_pins_in),
  .write_protect_in(write_protect_in), .standby_out(standby_out), .prog_busy_out(prog_busy_out));

// File: testbench/twe_ctrl_model.sv
// Behavioural two-wire bus controller
`timescale 1ns/1ps
module twe_ctrl_model (
  // Clock and resolved data line
  input wire logic clk_in,
  input wire logic sda_in,
  // Controller drives
  output logic scl_out,
  output logic pull_out
);
  // Idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  // Wait some system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One bit: data moves mid low phase, sampled mid high phase
  task automatic clock_bit(input logic b, output logic r);
    scl_out <= 1'b0;
    tick(2);
    pull_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
  endtask
  // Start (0) or stop (1): data edge with clock high
  task automatic cond(input logic stop);
    scl_out <= 1'b0;
    tick(2);
    pull_out <= stop;
    tick(2);
    scl_out <= 1'b1;
    tick(3);
    pull_out <= ~stop;
    tick(3);
  endtask
  // Send a byte MSB first, return the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], r);
    clock_bit(1'b1, r);
    ack = ~r;
  endtask
  // Receive a byte, then acknowledge to continue or not to end
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, r);
      d[i] = r;
    end
    clock_bit(~more, r);
  endtask
  // Bus recovery: nine released clocks, then start
  task automatic recover();
    logic r;
    repeat (9) clock_bit(1'b1, r);
    cond(1'b0);
  endtask
endmodule

// File: testbench/twe_target_test.sv
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/1ps
module twe_target_test import twe_pkg::*; ;
  localparam int PROG = 200; // Short programming run
  logic clk; // System clock
  logic srst; // Synchronous reset
  logic ce; // Clock enable, dropped once to freeze the block
  logic [2:0] pins; // Select straps
  logic wp; // Write protect
  logic scl; // Controller clock
  logic pull; // Controller pull-down
  logic sda_wire; // Resolved data line, pulled up
  logic oe; // Device pull-down
  logic standby; // Device idle
  logic busy; // Programming
  twe_bus_in_t bus; // Sampled bus pins
  int errors = 0;
  int total_checks = 0;
  assign sda_wire = ~(oe | pull);
  assign bus = {scl, sda_wire};
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  twe_target #(.DENSITY(DENS_8K), .PROG_CYCLES(PROG)) uut (
    .clk_in(clk), .srst_in(srst), .ce_in(ce), .bus_in(bus), .sda_out(), .sda_oe_out(oe),
    .device_select_pins_in(pins), .write_protect_in(wp), .standby_out(standby), .prog_busy_out(busy));
  twe_ctrl_model ctl (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .pull_out(pull));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Device word: type code, matching top select bit, page bits, direction
  function automatic logic [7:0] dev(input logic [1:0] pg, input logic rw);
    return {TWE_TYPE_CODE, 1'b1, pg, rw};
  endfunction
  // Bounded wait for programming to end
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 2 * PROG) begin
        errors++;
        print_verdict();
      end
    end
  endtask
  // Start, write device word and word address
  task automatic open_write(input logic [9:0] a);
    logic ack;
    ctl.cond(1'b0);
    ctl.send_byte(dev(a[9:8], 1'b0), ack);
    check(ack, 1);
    ctl.send_byte(a[7:0], ack);
    check(ack, 1);
  endtask
  // Write data bytes then stop
  task automatic write_seq(input logic [9:0] a, input logic [7:0] d[$]);
    logic ack;
    open_write(a);
    foreach (d[i]) begin
      ctl.send_byte(d[i], ack);
      check(ack, 1);
    end
    ctl.cond(1'b1);
    @(posedge clk);
  endtask
  // Random or current address read of expected bytes
  task automatic read_seq(input logic [9:0] a, input logic rnd, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] d;
    if (rnd)
      open_write(a);
    ctl.cond(1'b0);
    ctl.send_byte(dev(a[9:8], 1'b1), ack);
    check(ack, 1);
    foreach (e[i]) begin
      ctl.recv_byte(i < e.size() - 1, d);
      check(d, e[i]);
    end
    ctl.cond(1'b1);
    check(standby, 1);
  endtask
  // Page write wrapping inside its page, polling while busy
  task automatic s_page_wrap();
    logic ack;
    write_seq(10'h20e, '{8'haa, 8'hbb, 8'hcc});
    check(busy, 1);
    ctl.cond(1'b0);
    ctl.send_byte(dev(2'h2, 1'b0), ack);
    check(ack, 0);
    ctl.cond(1'b1);
    // Enable low must hold the programming timer where it stands
    ce <= 1'b0;
    repeat (PROG) @(posedge clk);
    check({busy, standby}, 2'b10);
    ce <= 1'b1;
    wait_idle();
    read_seq(10'h20e, 1, '{8'haa, 8'hbb});
    read_seq(10'h200, 1, '{8'hcc});
  endtask
  // Seventeen bytes overwrite the first; counter follows last write
  task automatic s_overflow();
    logic [7:0] d[$];
    for (int i = 0; i < 17; i++) d.push_back(8'h40 + 8'(i));
    write_seq(10'h100, d);
    wait_idle();
    read_seq(10'h000, 0, '{8'h41});
    read_seq(10'h100, 1, '{8'h50, 8'h41});
  endtask
  // Address mismatches, then ignored select pins
  task automatic s_address();
    logic ack;
    ctl.cond(1'b0);
    ctl.send_byte({TWE_TYPE_CODE, 1'b0, 2'h0, 1'b0}, ack);
    check({ack, standby}, 2'b01);
    ctl.send_byte(8'h00, ack);
    check(ack, 0);
    ctl.cond(1'b0);
    ctl.send_byte({~TWE_TYPE_CODE, 1'b1, 2'h0, 1'b0}, ack);
    check(ack, 0);
    pins <= 3'h6;
    ctl.cond(1'b0);
    ctl.send_byte(dev(2'h0, 1'b0), ack);
    check(ack, 1);
    ctl.cond(1'b1);
    check({busy, standby}, 2'b01);
    pins <= 3'h5;
  endtask
  // Protected write is acknowledged but changes nothing
  task automatic s_protect();
    wp <= 1'b1;
    write_seq(10'h200, '{8'h77});
    check(busy, 0);
    wp <= 1'b0;
    read_seq(10'h200, 1, '{8'hcc});
  endtask
  // Main sequence
  initial begin
    srst <= 1'b1;
    ce <= 1'b1;
    pins <= 3'h5;
    wp <= 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    ctl.recover();
    ctl.cond(1'b1);
    s_page_wrap();
    s_overflow();
    s_address();
    s_protect();
    print_verdict();
  end
endmodule
